// ===== rtl/tmu_defines.vh
// Register offsets, field positions, reset values and timing counts.
`ifndef TMU_DEFINES_VH
`define TMU_DEFINES_VH
`define TMU_IDX_CTRL       8'h80
`define TMU_IDX_AUX        8'h81
`define TMU_IDX_STAT       8'h82
`define TMU_IDX_LATCH      8'h84
`define TMU_CTRL_RESET     16'h0000
`define TMU_AUX_RESET      16'h0000
`define TMU_B_TEST         0
`define TMU_B_SRST         1
`define TMU_B_DDR          2
`define TMU_B_PAB          3
`define TMU_B_PCD          4
`define TMU_B_LEN_LO       5
`define TMU_B_LEN_HI       7
`define TMU_B_RCK_LO       8
`define TMU_B_RCK_HI       9
`define TMU_B_OTEN         10
`define TMU_B_OTCLR        11
`define TMU_B_SPOL         12
`define TMU_B_SEN          13
`define TMU_B_PWDN         14
`define TMU_B_RNG_LO       1
`define TMU_B_RNG_HI       2
`define TMU_B_QUIET        3
`define TMU_QUIET_MAX      5'h10
`define TMU_CLK_MHZ        50
`define TMU_SRST_US        250
`define TMU_SRST_CYC       (`TMU_SRST_US * `TMU_CLK_MHZ)
`define TMU_MEAS_CLR_CYC   4
`define TMU_PRE_CLR_CYC    3
`endif

// ===== rtl/tmu_latch.v
// Measurement and preconditioning latch pair for one event channel.
`timescale 1ns/1ps
`include "tmu_defines.vh"
module tmu_latch
(
    // Clock and reset
    input  wire       clk_sys,
    input  wire       arst_n,
    // Control
    input  wire       edge_neg,
    input  wire       gate,
    input  wire       lvl,
    // Latch state
    output reg        meas_reg,
    output reg        pre_reg
);
    reg        lvl_d_reg;
    reg        rearm_reg;
    reg [15:0] hi_cnt_reg;
    reg [15:0] lo_cnt_reg;
    reg [2:0]  mcnt_reg;
    reg [2:0]  pcnt_reg;
    wire       act  = lvl ^ edge_neg;
    wire       sel  = act & ~(lvl_d_reg ^ edge_neg);
    wire       take = sel & gate & rearm_reg & ~meas_reg;

    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lvl_d_reg  <= 1'b0;
            rearm_reg  <= 1'b1;
            hi_cnt_reg <= 16'h0000;
            lo_cnt_reg <= 16'h0000;
            meas_reg   <= 1'b0;
            pre_reg    <= 1'b0;
            mcnt_reg   <= 3'h0;
            pcnt_reg   <= 3'h0;
        end
        else
        begin
            lvl_d_reg <= lvl;
            if (take)
            begin
                meas_reg   <= 1'b1;
                pre_reg    <= 1'b1;
                rearm_reg  <= 1'b0;
                hi_cnt_reg <= 16'h0001;
                lo_cnt_reg <= 16'h0000;
            end
            else
            begin
                if (act && !rearm_reg)
                    hi_cnt_reg <= hi_cnt_reg + 16'h0001;
                else if (!act && !rearm_reg)
                begin
                    lo_cnt_reg <= lo_cnt_reg + 16'h0001;
                    if (lo_cnt_reg + 16'h0001 >= hi_cnt_reg && !meas_reg)
                        rearm_reg <= 1'b1;
                end
            end
            if (meas_reg && !take)
            begin
                mcnt_reg <= mcnt_reg + 3'h1;
                if (mcnt_reg == `TMU_MEAS_CLR_CYC - 1)
                begin
                    meas_reg <= 1'b0;
                    mcnt_reg <= 3'h0;
                end
            end
            if (pre_reg && !take)
            begin
                pcnt_reg <= pcnt_reg + 3'h1;
                if (pcnt_reg == `TMU_PRE_CLR_CYC - 1)
                begin
                    pre_reg  <= 1'b0;
                    pcnt_reg <= 3'h0;
                end
            end
        end
    end
endmodule

// ===== rtl/tmu_ccel.v
// Central control, status and event latches with Avalon-MM slave.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "tmu_defines.vh"
module tmu_ccel
#(
    parameter SRST_CYC = `TMU_SRST_CYC
)
(
    // Clock and reset
    input  wire        clk_sys,
    input  wire        arst_n,
    // Avalon-MM slave
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // Analog and loop status pins
    input  wire        overheat_pin,
    input  wire        sync_loop_unlock_pin,
    input  wire        fast_clock_loop_unlock_pin,
    input  wire        coarse_ok_pin,
    // Event inputs
    input  wire [3:0]  event_pin,
    input  wire        sync_pin,
    input  wire [4:0]  precond_gate,
    // Configuration outputs
    output reg         test_enable_reg,
    output reg         ddr_mode_reg,
    output reg  [2:0]  result_length_reg,
    output reg  [1:0]  result_clock_select_reg,
    output reg         power_down_reg,
    output reg  [1:0]  coarse_range_reg,
    output reg         result_clock_run_reg,
    output reg         in_reset_reg,
    // Latch outputs, channels A to D then sync
    output reg  [4:0]  meas_latch_reg,
    output reg  [4:0]  pre_latch_reg
);
    reg [15:0] ctrl_reg;
    reg [15:0] aux_reg;
    reg        alarm_reg;
    reg [31:0] srst_cnt_reg;
    reg [4:0]  stamp_cnt_reg;
    reg [4:0]  in_s1_reg;
    reg [4:0]  in_s2_reg;
    reg [2:0]  st_s1_reg;
    reg [2:0]  st_s2_reg;
    reg        coarse_s1_reg;
    reg        coarse_s2_reg;
    reg        ack_reg;
    reg [4:0]  ev_lvl;
    reg [4:0]  gate_all;
    wire [4:0] meas_w;
    wire [4:0] pre_w;
    wire       busy       = (srst_cnt_reg != 32'h0);
    wire       sel_ctrl   = (avs_address == `TMU_IDX_CTRL);
    wire       sel_aux    = (avs_address == `TMU_IDX_AUX);
    wire       sel_stat   = (avs_address == `TMU_IDX_STAT);
    wire       sel_latch  = (avs_address == `TMU_IDX_LATCH);
    wire       wr_ctrl    = avs_write & ack_reg & sel_ctrl;
    wire       wr_aux     = avs_write & ack_reg & sel_aux;
    wire       quiet      = aux_reg[`TMU_B_QUIET];
    wire       quiet_full = quiet & (stamp_cnt_reg == `TMU_QUIET_MAX);
    wire       sync_en    = ctrl_reg[`TMU_B_SEN];
    wire       ready;
    wire [15:0] status;

    assign ready = ~busy & ~power_down_reg & coarse_s2_reg &
                   ~st_s2_reg[1] & ~st_s2_reg[2] & sync_en;
    assign status = {12'h000, st_s2_reg[2], st_s2_reg[1], alarm_reg, ready};

    // Pin synchronisers.
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            in_s1_reg     <= 5'h00;
            in_s2_reg     <= 5'h00;
            st_s1_reg     <= 3'h0;
            st_s2_reg     <= 3'h0;
            coarse_s1_reg <= 1'b0;
            coarse_s2_reg <= 1'b0;
        end
        else
        begin
            in_s1_reg     <= {sync_pin, event_pin};
            in_s2_reg     <= in_s1_reg;
            st_s1_reg     <= {fast_clock_loop_unlock_pin,
                              sync_loop_unlock_pin, overheat_pin};
            st_s2_reg     <= st_s1_reg;
            coarse_s1_reg <= coarse_ok_pin;
            coarse_s2_reg <= coarse_s1_reg;
        end
    end

    // Input pairing and gating of each channel.
    always @*
    begin
        ev_lvl = in_s2_reg;
        if (ctrl_reg[`TMU_B_PAB])
            ev_lvl[1] = in_s2_reg[0];
        if (ctrl_reg[`TMU_B_PCD])
            ev_lvl[3] = in_s2_reg[2];
        gate_all = precond_gate & {5{~power_down_reg & ~busy & ~quiet_full}};
        gate_all[4] = gate_all[4] & sync_en;
    end

    // Event channels A to D take rising edges only.
    tmu_latch u_latch_a
    (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .edge_neg (1'b0),
        .gate     (gate_all[0]),
        .lvl      (ev_lvl[0]),
        .meas_reg (meas_w[0]),
        .pre_reg  (pre_w[0])
    );

    tmu_latch u_latch_b
    (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .edge_neg (1'b0),
        .gate     (gate_all[1]),
        .lvl      (ev_lvl[1]),
        .meas_reg (meas_w[1]),
        .pre_reg  (pre_w[1])
    );

    tmu_latch u_latch_c
    (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .edge_neg (1'b0),
        .gate     (gate_all[2]),
        .lvl      (ev_lvl[2]),
        .meas_reg (meas_w[2]),
        .pre_reg  (pre_w[2])
    );

    tmu_latch u_latch_d
    (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .edge_neg (1'b0),
        .gate     (gate_all[3]),
        .lvl      (ev_lvl[3]),
        .meas_reg (meas_w[3]),
        .pre_reg  (pre_w[3])
    );

    tmu_latch u_latch_sync
    (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .edge_neg (ctrl_reg[`TMU_B_SPOL]),
        .gate     (gate_all[4]),
        .lvl      (ev_lvl[4]),
        .meas_reg (meas_w[4]),
        .pre_reg  (pre_w[4])
    );

    // Bus acknowledge, control and auxiliary registers.
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_reg <= `TMU_CTRL_RESET;
            aux_reg  <= `TMU_AUX_RESET;
            ack_reg  <= 1'b0;
        end
        else
        begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
            if (wr_ctrl && avs_writedata[`TMU_B_SRST])
            begin
                ctrl_reg <= `TMU_CTRL_RESET;
                aux_reg  <= `TMU_AUX_RESET;
            end
            else
            begin
                if (wr_ctrl)
                    ctrl_reg <= avs_writedata[15:0] &
                                ~(16'h0001 << `TMU_B_SRST) &
                                ~(16'h0001 << `TMU_B_OTCLR);
                if (wr_aux)
                    aux_reg <= avs_writedata[15:0] & 16'h000e;
            end
        end
    end

    // soft reset busy time
    // A new soft reset write restarts the busy count.
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            srst_cnt_reg <= 32'h0;
        else if (wr_ctrl && avs_writedata[`TMU_B_SRST])
            srst_cnt_reg <= SRST_CYC;
        else if (busy)
            srst_cnt_reg <= srst_cnt_reg - 32'h1;
    end

    // alarm clear, set wins
    // The alarm holds after the pin falls until it is cleared.
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            alarm_reg <= 1'b0;
        else if (ctrl_reg[`TMU_B_OTEN] && st_s2_reg[0])
            alarm_reg <= 1'b1;
        else if ((wr_ctrl && avs_writedata[`TMU_B_OTCLR]) ||
                 !ctrl_reg[`TMU_B_OTEN])
            alarm_reg <= 1'b0;
    end

    // count quiet stamps
    // A stamp counts once, on the cycle after its latch rises.
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            stamp_cnt_reg <= 5'h00;
        else if (!quiet || busy)
            stamp_cnt_reg <= 5'h00;
        else if (|(meas_w & ~meas_latch_reg) && !quiet_full)
            stamp_cnt_reg <= stamp_cnt_reg + 5'h01;
    end

    // Read data and wait request.
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            avs_readdata    <= 32'h0;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            // One wait state: low in the cycle after a request is seen.
            avs_waitrequest <= ~((avs_read | avs_write) & ~ack_reg);
            if (avs_read && !ack_reg)
            begin
                if (sel_ctrl)
                    avs_readdata <= {16'h0, ctrl_reg};
                else if (sel_aux)
                    avs_readdata <= {16'h0, aux_reg};
                else if (sel_stat)
                    avs_readdata <= {16'h0, status};
                else if (sel_latch)
                    avs_readdata <= {22'h0, pre_w, meas_w};
                else
                    avs_readdata <= 32'h0;
            end
        end
    end

    // Configuration copies and clock run.
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            test_enable_reg         <= 1'b0;
            ddr_mode_reg            <= 1'b0;
            result_length_reg       <= 3'h0;
            result_clock_select_reg <= 2'h0;
            power_down_reg          <= 1'b0;
            coarse_range_reg        <= 2'h0;
            result_clock_run_reg    <= 1'b0;
            in_reset_reg            <= 1'b0;
        end
        else
        begin
            test_enable_reg         <= ctrl_reg[`TMU_B_TEST];
            ddr_mode_reg            <= ctrl_reg[`TMU_B_DDR];
            result_length_reg       <= ctrl_reg[`TMU_B_LEN_HI:`TMU_B_LEN_LO];
            result_clock_select_reg <= ctrl_reg[`TMU_B_RCK_HI:`TMU_B_RCK_LO];
            power_down_reg          <= ctrl_reg[`TMU_B_PWDN];
            coarse_range_reg        <= aux_reg[`TMU_B_RNG_HI:`TMU_B_RNG_LO];
            result_clock_run_reg    <= ~ctrl_reg[`TMU_B_PWDN] & ~busy &
                                       ~(quiet & (|meas_w));
            in_reset_reg            <= busy;
        end
    end

    // Latch state copies.
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meas_latch_reg <= 5'h00;
            pre_latch_reg  <= 5'h00;
        end
        else
        begin
            meas_latch_reg <= meas_w;
            pre_latch_reg  <= pre_w;
        end
    end
endmodule

// ===== bench/tmu_ccel_props.sv
// Concurrent checks on the ports of the control and latch block.
`timescale 1ns/1ps
module tmu_ccel_props
#(
    parameter SRST_CYC = 20
)
(
    input wire       clk_sys,
    input wire       arst_n,
    input wire       avs_read,
    input wire       avs_write,
    input wire       avs_waitrequest,
    input wire [4:0] precond_gate,
    input wire       ddr_mode_reg,
    input wire       power_down_reg,
    input wire       result_clock_run_reg,
    input wire       in_reset_reg,
    input wire [4:0] meas_latch_reg,
    input wire [4:0] pre_latch_reg
);
    reg [15:0] busy_cnt_reg;
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            busy_cnt_reg <= 16'h0000;
        else
            busy_cnt_reg <= in_reset_reg ? busy_cnt_reg + 16'h0001 : 16'h0000;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    AST_ACK: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("No acknowledge one cycle after request");
    AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Acknowledge longer than one cycle");
    AST_SRST: assert property ($fell(in_reset_reg) |->
        (busy_cnt_reg >= SRST_CYC - 1 && busy_cnt_reg <= SRST_CYC + 1))
        else $error("Soft reset busy time wrong");
    AST_DDR: assert property ($changed(ddr_mode_reg) |-> $past(avs_write) ||
        $past(avs_write, 2) || in_reset_reg || $past(in_reset_reg))
        else $error("Double rate mode changed without a write");
    AST_PWDN: assert property (power_down_reg [*2] |-> !result_clock_run_reg)
        else $error("Result clock runs while powered down");
    AST_MEAS: assert property ($rose(meas_latch_reg[0]) |->
        meas_latch_reg[0] [*3] ##[1:6] !meas_latch_reg[0])
        else $error("Measurement latch hold time wrong");
    AST_GATE: assert property (!precond_gate[0] [*3] |-> !$rose(meas_latch_reg[0]))
        else $error("Latch set while gated off");
    AST_PRE: assert property ($fell(pre_latch_reg[0]) |-> meas_latch_reg[0])
        else $error("Second latch not cleared first");
    cover property ($rose(meas_latch_reg[4]));
    cover property ($fell(in_reset_reg));
    cover property (power_down_reg);
endmodule
bind tmu_ccel tmu_ccel_props #(.SRST_CYC(SRST_CYC)) props_u
(
    .clk_sys              (clk_sys),
    .arst_n               (arst_n),
    .avs_read             (avs_read),
    .avs_write            (avs_write),
    .avs_waitrequest      (avs_waitrequest),
    .precond_gate         (precond_gate),
    .ddr_mode_reg         (ddr_mode_reg),
    .power_down_reg       (power_down_reg),
    .result_clock_run_reg (result_clock_run_reg),
    .in_reset_reg         (in_reset_reg),
    .meas_latch_reg       (meas_latch_reg),
    .pre_latch_reg        (pre_latch_reg)
);

// ===== bench/tmu_evt_src.sv
// Event source model driving the channel and sync pins.
`timescale 1ns/1ps
module tmu_evt_src
(
    // Clock
    input  wire       clk_sys,
    // Event pins
    output reg  [3:0] event_pin,
    output reg        sync_pin
);
    initial
    begin
        event_pin = 4'h0;
        sync_pin = 1'b0;
    end
    // edge spacing
    // Pulses span whole clock periods, so edges stay far apart.
    task pulse(input [4:0] m, input integer hi, input integer lo);
    begin
        @(posedge clk_sys);
        {sync_pin, event_pin} <= m;
        repeat (hi) @(posedge clk_sys);
        {sync_pin, event_pin} <= 5'h00;
        repeat (lo) @(posedge clk_sys);
    end
    endtask
endmodule

// ===== bench/tmu_ccel_tb.sv
// Self-checking testbench for the control, status and latch block.
`timescale 1ns/1ps
module tmu_ccel_tb;
    localparam SRST = 20;
    reg         clk_sys;
    reg         arst_n;
    reg  [7:0]  avs_address;
    reg         avs_read;
    reg         avs_write;
    reg  [31:0] avs_writedata;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    reg         overheat_pin;
    reg         sync_loop_unlock_pin;
    reg         fast_clock_loop_unlock_pin;
    reg         coarse_ok_pin;
    wire [3:0]  event_pin;
    wire        sync_pin;
    reg  [4:0]  precond_gate;
    wire        test_enable_reg, ddr_mode_reg, power_down_reg;
    wire        result_clock_run_reg, in_reset_reg;
    wire [2:0]  result_length_reg;
    wire [1:0]  result_clock_select_reg, coarse_range_reg;
    wire [4:0]  meas_latch_reg, pre_latch_reg;
    reg  [31:0] q;
    reg  [15:0] d;
    integer     mismatches, checked, i, n, ft, ft0;
    tmu_ccel #(.SRST_CYC(SRST)) dut_u
    (
        .clk_sys                    (clk_sys),
        .arst_n                     (arst_n),
        .avs_address                (avs_address),
        .avs_read                   (avs_read),
        .avs_write                  (avs_write),
        .avs_writedata              (avs_writedata),
        .avs_readdata               (avs_readdata),
        .avs_waitrequest            (avs_waitrequest),
        .overheat_pin               (overheat_pin),
        .sync_loop_unlock_pin       (sync_loop_unlock_pin),
        .fast_clock_loop_unlock_pin (fast_clock_loop_unlock_pin),
        .coarse_ok_pin              (coarse_ok_pin),
        .event_pin                  (event_pin),
        .sync_pin                   (sync_pin),
        .precond_gate               (precond_gate),
        .test_enable_reg            (test_enable_reg),
        .ddr_mode_reg               (ddr_mode_reg),
        .result_length_reg          (result_length_reg),
        .result_clock_select_reg    (result_clock_select_reg),
        .power_down_reg             (power_down_reg),
        .coarse_range_reg           (coarse_range_reg),
        .result_clock_run_reg       (result_clock_run_reg),
        .in_reset_reg               (in_reset_reg),
        .meas_latch_reg             (meas_latch_reg),
        .pre_latch_reg              (pre_latch_reg)
    );
    tmu_evt_src src_u (.clk_sys(clk_sys), .event_pin(event_pin),
        .sync_pin(sync_pin));
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task chk(input [31:0] got, input [31:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task acc(input [7:0] a, input w, input [15:0] wd);
    begin
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {16'h0000, wd};
        n = 0;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            n = n + 1;
            @(posedge clk_sys);
        end
        chk(n < 50, 1);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    end
    endtask
    task rd(input [7:0] a, input [15:0] e);
    begin
        acc(a, 1'b0, 16'h0000);
        chk(q, {16'h0000, e});
    end
    endtask
    task st(input [3:0] p, input [15:0] c, input [15:0] e);
    begin
        {overheat_pin, sync_loop_unlock_pin} <= p[3:2];
        {fast_clock_loop_unlock_pin, coarse_ok_pin} <= p[1:0];
        acc(8'h80, 1'b1, c);
        repeat (4) @(posedge clk_sys);
        rd(8'h82, e);
    end
    endtask
    // Pulses m, then m2 after lo+1 idle cycles; counts latch b sets.
    task ev(input [4:0] m, input integer lo, input [4:0] m2,
        input integer b, input [4:0] e);
        integer   k;
        reg       last;
        reg       stop;
        reg [3:0] cnt;
        reg       lastp;
        reg [3:0] pc;
    begin
        cnt = 4'h0;
        pc = 4'h0;
        lastp = 1'b0;
        last = 1'b0;
        stop = 1'b0;
        ft = 0;
        fork
            begin
                src_u.pulse(m, 2, lo);
                src_u.pulse(m2, 2, 4);
            end
            for (k = 1; k < 30; k = k + 1)
            begin
                @(posedge clk_sys);
                if (meas_latch_reg[b] && !last && ft == 0)
                    ft = k;
                if (meas_latch_reg[b] && !last)
                    cnt = cnt + 4'h1;
                stop = stop | (meas_latch_reg[b] & !result_clock_run_reg);
                last = meas_latch_reg[b];
                if (pre_latch_reg[b] && !lastp)
                    pc = pc + 4'h1;
                lastp = pre_latch_reg[b];
            end
        join
        chk({stop, cnt}, e);
        chk(pc, e[3:0]);
    end
    endtask
    task end_of_test;
    begin
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        mismatches = mismatches + 1;
        end_of_test;
    end
    initial
    begin
        {arst_n, avs_read, avs_write, avs_address, avs_writedata} = 0;
        {overheat_pin, sync_loop_unlock_pin} = 2'b00;
        {fast_clock_loop_unlock_pin, coarse_ok_pin} = 2'b01;
        precond_gate = 5'h1f;
        mismatches = 0;
        checked = 0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(8'h80, 16'h0000);
        rd(8'h81, 16'h0000);
        rd(8'h90, 16'h0000);
        for (i = 0; i < 3; i = i + 1)
        begin
            d = (i == 0) ? 16'h7ffd : (i == 1) ? 16'h0aa5 : 16'h0000;
            acc(8'h80, 1'b1, d);
            repeat (2) @(posedge clk_sys);
            chk({test_enable_reg, ddr_mode_reg, result_length_reg,
                result_clock_select_reg, power_down_reg, result_clock_run_reg},
                {d[0], d[2], d[7:5], d[9:8], d[14], !d[14]});
            rd(8'h80, d & 16'hf7fd);
        end
        acc(8'h81, 1'b1, 16'hffff);
        repeat (2) @(posedge clk_sys);
        chk(coarse_range_reg, 2'b11);
        rd(8'h81, 16'h000e);
        acc(8'h81, 1'b1, 16'h0000);
        st(4'b0001, 16'h2000, 16'h0001);
        st(4'b0000, 16'h2000, 16'h0000);
        st(4'b0101, 16'h2000, 16'h0004);
        st(4'b0011, 16'h2000, 16'h0008);
        st(4'b1001, 16'h2400, 16'h0003);
        st(4'b1001, 16'h2000, 16'h0001);
        st(4'b1001, 16'h2400, 16'h0003);
        st(4'b0001, 16'h2400, 16'h0003);
        st(4'b0001, 16'h2c00, 16'h0001);
        st(4'b0001, 16'h6000, 16'h0000);
        st(4'b0001, 16'h0000, 16'h0000);
        acc(8'h82, 1'b1, 16'hffff);
        rd(8'h82, 16'h0000);
        acc(8'h80, 1'b1, 16'h2000);
        ev(5'h01, 9, 5'h00, 0, 5'h01);
        ev(5'h01, 9, 5'h00, 1, 5'h00);
        ev(5'h04, 9, 5'h00, 3, 5'h00);
        ev(5'h01, 0, 5'h01, 0, 5'h01);
        ev(5'h01, 9, 5'h01, 0, 5'h02);
        ev(5'h10, 9, 5'h00, 4, 5'h01);
        ft0 = ft;
        acc(8'h80, 1'b1, 16'h3000);
        ev(5'h10, 9, 5'h00, 4, 5'h01);
        chk(ft - ft0, 2);
        acc(8'h80, 1'b1, 16'h2018);
        ev(5'h01, 9, 5'h00, 1, 5'h01);
        ev(5'h04, 9, 5'h00, 3, 5'h01);
        acc(8'h80, 1'b1, 16'h0000);
        ev(5'h10, 9, 5'h00, 4, 5'h00);
        acc(8'h80, 1'b1, 16'h2000);
        precond_gate <= 5'h1e;
        ev(5'h01, 9, 5'h00, 0, 5'h00);
        precond_gate <= 5'h1f;
        acc(8'h81, 1'b1, 16'h0008);
        ev(5'h01, 9, 5'h00, 0, 5'h11);
        for (i = 0; i < 7; i = i + 1)
            ev(5'h01, 9, 5'h01, 0, 5'h12);
        ev(5'h01, 9, 5'h01, 0, 5'h11);
        rd(8'h84, 16'h0000);
        acc(8'h80, 1'b1, 16'h2002);
        repeat (2) @(posedge clk_sys);
        chk(in_reset_reg, 1'b1);
        repeat (SRST + 4) @(posedge clk_sys);
        chk(in_reset_reg, 1'b0);
        rd(8'h80, 16'h0000);
        rd(8'h81, 16'h0000);
        end_of_test;
    end
endmodule
